// >>> verilog/tfb_pkg.sv
package tfb_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h10;
  localparam logic [7:0] OFF_BUF_BASE = 8'h20;
  localparam logic [7:0] OFF_CC_BASE = 8'h30;
  localparam logic [7:0] OFF_STRIDE = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // timer_status_flags field positions
  localparam int POS_CMP = 24;
  localparam int POS_BUFV = 16;
  localparam int POS_NRF = 14;
  localparam int POS_RFB = 13;
  localparam int POS_RFA = 12;
  localparam int POS_NRF_IN = 10;
  localparam int POS_RFB_IN = 9;
  localparam int POS_RFA_IN = 8;
  localparam int NUM_NRF = 2;

  ////////////////////////////////////////////////////////////////////////////
  // control register fields and reset value
  localparam int POS_LOCK_UPDATE = 0;
  localparam int POS_HALT_SW = 1;
  localparam int POS_CAPT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status / clear / enable layout
  localparam int IRQ_W = 8;
  localparam int IRQ_NRF = 0;
  localparam int IRQ_RFB = 2;
  localparam int IRQ_RFA = 3;
  localparam int IRQ_CAPT = 4;
  localparam logic [7:0] IRQ_RST = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tfb_bus_req_t;

  typedef struct packed {
    logic [1:0] nonrecov;
    logic recov_b;
    logic recov_a;
  } tfb_fault_in_t;

endpackage

// >>> verilog/tfb_sync2.sv
`timescale 1ns/1ps
module tfb_sync2 #(
  parameter int W = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = d_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign q_o = sync_r;

endmodule

// >>> verilog/tfb_chan.sv
`timescale 1ns/1ps
module tfb_chan #(
  parameter int DW = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic capture_mode_i,
  input wire logic lock_update_i,
  input wire logic buf_wr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic bufv_clr_wr_i,
  input wire logic update_i,
  input wire logic capt_stb_i,
  input wire logic [DW-1:0] capt_val_i,
  input wire logic cc_rd_i,
  output logic [DW-1:0] buf_o,
  output logic [DW-1:0] cc_o,
  output logic bufv_o,
  output logic capt_evt_o
);

  logic [DW-1:0] buf_r;
  logic [DW-1:0] buf_nxt;
  logic [DW-1:0] cc_r;
  logic [DW-1:0] cc_nxt;
  logic bufv_r;
  logic bufv_nxt;

  always_comb begin
    buf_nxt = buf_r;
    cc_nxt = cc_r;
    bufv_nxt = bufv_r;
    if (capture_mode_i) begin
      // a read of the capture register clears the buffer valid flag
      if (cc_rd_i) begin
        bufv_nxt = 1'b0;
      end
      // a capture in the same cycle as the read keeps the flag set
      if (capt_stb_i) begin
        buf_nxt = capt_val_i;
        cc_nxt = capt_val_i;
        bufv_nxt = 1'b1;
      end
    end else begin
      if (bufv_clr_wr_i && lock_update_i) begin
        bufv_nxt = 1'b0;
      end
      if (update_i && bufv_r) begin
        cc_nxt = buf_r;
        bufv_nxt = 1'b0;
      end
      // a new buffer write wins over any clear in the same cycle
      if (buf_wr_i) begin
        buf_nxt = wdata_i;
        bufv_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_r <= '0;
      cc_r <= '0;
      bufv_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      cc_r <= cc_nxt;
      bufv_r <= bufv_nxt;
    end
  end

  assign buf_o = buf_r;
  assign cc_o = cc_r;
  assign bufv_o = bufv_r;
  assign capt_evt_o = capture_mode_i & capt_stb_i;

endmodule

// >>> verilog/tfb_top.sv
// Operation
// - Each channel compare level bit reads the live compare output level of its channel.
// - A compare channel sets its buffer valid flag when software writes its buffer register.
// - A compare buffer valid flag clears on a write of one under lock update, or on update.
// - A capture channel sets its buffer valid flag when a captured value is stored.
// - Reading a capture channel's capture/compare register clears its buffer valid flag.
// - A non-recoverable fault state bit sets as soon as its fault condition is seen.
// - A non-recoverable fault state bit clears only on a write of one while its input is low.
// - After a non-recoverable fault clears, the counter resumes from its held count.
// - The recoverable fault B state bit sets as soon as its fault condition is seen.
// - Fault B state clears on hardware resume, or on a write of one while its input is low.
// - With software halt release, clearing fault B state releases the halted counter.
`timescale 1ns/1ps
module tfb_top #(
  parameter int DW = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire tfb_pkg::tfb_bus_req_t bus_req_i,
  output logic [31:0] rdata_o,
  input wire logic [tfb_pkg::NUM_CH-1:0] chan_compare_level_i,
  input wire tfb_pkg::tfb_fault_in_t fault_pins_i,
  input wire logic recov_fault_a_resume_i,
  input wire logic recov_fault_b_resume_i,
  input wire logic update_i,
  input wire logic [tfb_pkg::NUM_CH-1:0] capt_stb_i,
  input wire logic [tfb_pkg::NUM_CH*DW-1:0] capt_val_i,
  output logic [tfb_pkg::NUM_CH*DW-1:0] cc_value_o,
  output logic counter_halt_o,
  output logic irq_o
);

  localparam int NCH = tfb_pkg::NUM_CH;
  localparam int NNRF = tfb_pkg::NUM_NRF;
  localparam int FW = $bits(tfb_pkg::tfb_fault_in_t);

  ////////////////////////////////////////////////////////////////////////////
  // fault pin synchronisation

  logic [FW-1:0] fault_sync;
  tfb_pkg::tfb_fault_in_t flt_lvl;

  tfb_sync2 #(
    .W(FW)
  ) u_fault_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(fault_pins_i),
    .q_o(fault_sync)
  );

  assign flt_lvl = fault_sync;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic wr_status;
  logic wr_ctrl;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic [NCH-1:0] buf_wr;
  logic [NCH-1:0] cc_rd;
  logic [NCH-1:0] bufv_clr_wr;
  // channel registers sit one stride apart above their base offsets

  always_comb begin
    wr_status = bus_req_i.wr && (bus_req_i.addr == tfb_pkg::OFF_STATUS);
    wr_ctrl = bus_req_i.wr && (bus_req_i.addr == tfb_pkg::OFF_CTRL);
    wr_irq_clr = bus_req_i.wr && (bus_req_i.addr == tfb_pkg::OFF_IRQ_CLR);
    wr_irq_en = bus_req_i.wr && (bus_req_i.addr == tfb_pkg::OFF_IRQ_EN);
    for (int i = 0; i < NCH; i++) begin
      buf_wr[i] = bus_req_i.wr &&
        (bus_req_i.addr == tfb_pkg::OFF_BUF_BASE + 8'(i) * tfb_pkg::OFF_STRIDE);
      cc_rd[i] = bus_req_i.rd &&
        (bus_req_i.addr == tfb_pkg::OFF_CC_BASE + 8'(i) * tfb_pkg::OFF_STRIDE);
      bufv_clr_wr[i] = wr_status && bus_req_i.wdata[tfb_pkg::POS_BUFV + i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic lock_update;
  logic halt_sw;
  logic [NCH-1:0] capture_mode;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      // unused control bits read back as zero
      ctrl_nxt = 32'h0000_0000;
      ctrl_nxt[tfb_pkg::POS_LOCK_UPDATE] = bus_req_i.wdata[tfb_pkg::POS_LOCK_UPDATE];
      ctrl_nxt[tfb_pkg::POS_HALT_SW] = bus_req_i.wdata[tfb_pkg::POS_HALT_SW];
      ctrl_nxt[tfb_pkg::POS_CAPT +: NCH] = bus_req_i.wdata[tfb_pkg::POS_CAPT +: NCH];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= tfb_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign lock_update = ctrl_r[tfb_pkg::POS_LOCK_UPDATE];
  assign halt_sw = ctrl_r[tfb_pkg::POS_HALT_SW];
  assign capture_mode = ctrl_r[tfb_pkg::POS_CAPT +: NCH];

  ////////////////////////////////////////////////////////////////////////////
  // channels

  logic [DW-1:0] buf_w [NCH];
  logic [DW-1:0] cc_w [NCH];
  logic [NCH-1:0] bufv;
  logic [NCH-1:0] capt_evt;

  // each channel keeps its own buffer, capture/compare register and valid flag
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    tfb_chan #(
      .DW(DW)
    ) u_chan (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .capture_mode_i(capture_mode[g]),
      .lock_update_i(lock_update),
      .buf_wr_i(buf_wr[g]),
      .wdata_i(bus_req_i.wdata[DW-1:0]),
      .bufv_clr_wr_i(bufv_clr_wr[g]),
      .update_i(update_i),
      .capt_stb_i(capt_stb_i[g]),
      .capt_val_i(capt_val_i[g*DW +: DW]),
      .cc_rd_i(cc_rd[g]),
      .buf_o(buf_w[g]),
      .cc_o(cc_w[g]),
      .bufv_o(bufv[g]),
      .capt_evt_o(capt_evt[g])
    );
    assign cc_value_o[g*DW +: DW] = cc_w[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault state bits

  logic [NNRF-1:0] nrf_r;
  logic [NNRF-1:0] nrf_nxt;
  logic rfb_r;
  logic rfb_nxt;
  logic rfa_r;
  logic rfa_nxt;
  logic halt_r;
  logic halt_nxt;
  // a live fault input wins over a software clear in the same cycle
  // fault a behaves like fault b but never halts the counter

  always_comb begin
    nrf_nxt = nrf_r;
    rfb_nxt = rfb_r;
    rfa_nxt = rfa_r;
    for (int i = 0; i < NNRF; i++) begin
      if (wr_status && bus_req_i.wdata[tfb_pkg::POS_NRF + i] && !flt_lvl.nonrecov[i]) begin
        nrf_nxt[i] = 1'b0;
      end
      if (flt_lvl.nonrecov[i]) begin
        nrf_nxt[i] = 1'b1;
      end
    end
    if (recov_fault_b_resume_i ||
        (wr_status && bus_req_i.wdata[tfb_pkg::POS_RFB] && !flt_lvl.recov_b)) begin
      rfb_nxt = 1'b0;
    end
    if (flt_lvl.recov_b) begin
      rfb_nxt = 1'b1;
    end
    if (recov_fault_a_resume_i ||
        (wr_status && bus_req_i.wdata[tfb_pkg::POS_RFA] && !flt_lvl.recov_a)) begin
      rfa_nxt = 1'b0;
    end
    if (flt_lvl.recov_a) begin
      rfa_nxt = 1'b1;
    end
    // halt follows the next state so it changes at the same edge as the state bits
    // the counter only holds its value while halted, so release resumes from it
    halt_nxt = (|nrf_nxt) | (rfb_nxt & halt_sw);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nrf_r <= '0;
      rfb_r <= 1'b0;
      rfa_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      nrf_r <= nrf_nxt;
      rfb_r <= rfb_nxt;
      rfa_r <= rfa_nxt;
      halt_r <= halt_nxt;
    end
  end

  assign counter_halt_o = halt_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  logic [tfb_pkg::IRQ_W-1:0] irq_status_r;
  logic [tfb_pkg::IRQ_W-1:0] irq_status_nxt;
  logic [tfb_pkg::IRQ_W-1:0] irq_en_r;
  logic [tfb_pkg::IRQ_W-1:0] irq_en_nxt;
  logic [tfb_pkg::IRQ_W-1:0] irq_evt;
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    // fault events fire on the rising edge of each state bit, not on its level
    irq_evt = '0;
    irq_evt[tfb_pkg::IRQ_NRF +: NNRF] = flt_lvl.nonrecov & ~nrf_r;
    irq_evt[tfb_pkg::IRQ_RFB] = flt_lvl.recov_b & ~rfb_r;
    irq_evt[tfb_pkg::IRQ_RFA] = flt_lvl.recov_a & ~rfa_r;
    irq_evt[tfb_pkg::IRQ_CAPT +: NCH] = capt_evt;
    irq_status_nxt = irq_status_r;
    if (wr_irq_clr) begin
      irq_status_nxt = irq_status_r & ~bus_req_i.wdata[tfb_pkg::IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    irq_status_nxt = irq_status_nxt | irq_evt;
    irq_en_nxt = irq_en_r;
    if (wr_irq_en) begin
      irq_en_nxt = bus_req_i.wdata[tfb_pkg::IRQ_W-1:0];
    end
    // taken from next values so the line rises at the edge that records the event
    irq_nxt = |(irq_status_nxt & irq_en_nxt);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_r <= tfb_pkg::IRQ_RST;
      irq_en_r <= tfb_pkg::IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq_o = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe

  logic [31:0] status_word;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[tfb_pkg::POS_CMP +: NCH] = chan_compare_level_i;
    status_word[tfb_pkg::POS_BUFV +: NCH] = bufv;
    status_word[tfb_pkg::POS_NRF +: NNRF] = nrf_r;
    status_word[tfb_pkg::POS_RFB] = rfb_r;
    status_word[tfb_pkg::POS_RFA] = rfa_r;
    status_word[tfb_pkg::POS_NRF_IN +: NNRF] = flt_lvl.nonrecov;
    status_word[tfb_pkg::POS_RFB_IN] = flt_lvl.recov_b;
    status_word[tfb_pkg::POS_RFA_IN] = flt_lvl.recov_a;
  end

  always_comb begin
    // unmapped addresses and the write-only clear register read as zero
    rdata_nxt = 32'h0000_0000;
    if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        tfb_pkg::OFF_STATUS: rdata_nxt = status_word;
        tfb_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
        tfb_pkg::OFF_IRQ_STATUS: rdata_nxt = {24'h00_0000, irq_status_r};
        tfb_pkg::OFF_IRQ_EN: rdata_nxt = {24'h00_0000, irq_en_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (bus_req_i.addr == tfb_pkg::OFF_BUF_BASE + 8'(i) * tfb_pkg::OFF_STRIDE) begin
          rdata_nxt = buf_w[i];
        end
        // this read also empties the valid flag of a capture channel
        if (cc_rd[i]) begin
          rdata_nxt = cc_w[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule

// >>> bench/tfb_properties.sv
`timescale 1ns/1ps
module tfb_properties #(
  parameter int DW = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire tfb_pkg::tfb_bus_req_t bus_req_i,
  input wire logic [31:0] rdata_o,
  input wire logic [tfb_pkg::NUM_CH-1:0] chan_compare_level_i,
  input wire tfb_pkg::tfb_fault_in_t fault_pins_i,
  input wire logic recov_fault_a_resume_i,
  input wire logic recov_fault_b_resume_i,
  input wire logic update_i,
  input wire logic [tfb_pkg::NUM_CH-1:0] capt_stb_i,
  input wire logic [tfb_pkg::NUM_CH*DW-1:0] capt_val_i,
  input wire logic [tfb_pkg::NUM_CH*DW-1:0] cc_value_o,
  input wire logic counter_halt_o,
  input wire logic irq_o
);
  logic [7:0] en_r, en_nxt;
  logic [3:0] cap_r, cap_nxt;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of irq enable and capture mode
  always_comb begin
    en_nxt = en_r;
    cap_nxt = cap_r;
    if (bus_req_i.wr && bus_req_i.addr == tfb_pkg::OFF_IRQ_EN) begin
      en_nxt = bus_req_i.wdata[7:0];
    end
    if (bus_req_i.wr && bus_req_i.addr == tfb_pkg::OFF_CTRL) begin
      cap_nxt = bus_req_i.wdata[7:4];
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_r <= 8'h00;
      cap_r <= 4'h0;
    end else begin
      en_r <= en_nxt;
      cap_r <= cap_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_status_rd;
    bus_req_i.rd && bus_req_i.addr == tfb_pkg::OFF_STATUS;
  endsequence
  sequence s_status_wr;
    bus_req_i.wr && bus_req_i.addr == tfb_pkg::OFF_STATUS;
  endsequence
  sequence s_nrf_held;
    (fault_pins_i.nonrecov != 2'b00) [*4];
  endsequence
  a_cmp_live: assert property (s_status_rd |=>
    rdata_o[27:24] == $past(chan_compare_level_i)) else $error("compare level mismatch");
  a_rdata_idle: assert property (!bus_req_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_nrf_halt: assert property (s_nrf_held |-> ##[0:3] counter_halt_o)
    else $error("halt missing on fault");
  a_nrf_block: assert property (s_nrf_held ##0 s_status_wr |=> counter_halt_o)
    else $error("fault cleared while input high");
  a_halt_sticky: assert property (
    counter_halt_o && !bus_req_i.wr && !recov_fault_b_resume_i |=> counter_halt_o)
    else $error("halt dropped without cause");
  a_irq_enabled: assert property (irq_o |-> en_r != 8'h00) else $error("irq without enable");
  a_capt_irq: assert property ((capt_stb_i & cap_r & en_r[7:4]) != 4'h0 |=> irq_o)
    else $error("capture irq missing");
  a_capt_load: assert property (capt_stb_i[0] && cap_r[0] |=>
    cc_value_o[DW-1:0] == $past(capt_val_i[DW-1:0])) else $error("capture not loaded");
  a_cmp_hold: assert property (cap_r == 4'h0 && !update_i |=> $stable(cc_value_o))
    else $error("compare reg changed without update");
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i, rst_i, res_a, res_b, upd, halt, irq, rd_q;
  tfb_pkg::tfb_bus_req_t bus_req;
  tfb_pkg::tfb_fault_in_t pins;
  logic [31:0] rdata, v;
  logic [3:0] cmp_lvl, capt_stb;
  logic [127:0] capt_val, cc_val;
  logic [31:0] exp_q[$], msk_q[$];
  int n_mismatch = 0, num_checks = 0, seed = 32'h46e4210e;
  tfb_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req), .rdata_o(rdata),
    .chan_compare_level_i(cmp_lvl), .fault_pins_i(pins), .recov_fault_a_resume_i(res_a),
    .recov_fault_b_resume_i(res_b), .update_i(upd), .capt_stb_i(capt_stb),
    .capt_val_i(capt_val), .cc_value_o(cc_val), .counter_halt_o(halt), .irq_o(irq));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge ref_clk_i);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_halt(input logic h);
    for (int i = 0; i < 10 && halt !== h; i++) @(posedge ref_clk_i);
    chk("counter_halt", {31'h0, halt}, {31'h0, h});
    if (halt !== h) results();
  endtask
  task automatic cap(input int i, input logic [31:0] d);
    @(posedge ref_clk_i);
    capt_val[32*i +: 32] <= d;
    capt_stb <= 4'h1 << i;
    @(posedge ref_clk_i);
    capt_stb <= 4'h0;
    idle(1);
  endtask
  // raise a fault, try an early clear, drop it, clear it (0 write, 1 resume a, 2 resume b)
  task automatic flt(input logic [3:0] p, input logic [31:0] st, input logic h, input int how);
    @(posedge ref_clk_i);
    pins <= tfb_pkg::tfb_fault_in_t'(p);
    idle(5);
    wait_halt(h);
    rd(tfb_pkg::OFF_STATUS, st | (st >> 4), 32'hff00);
    rd(tfb_pkg::OFF_IRQ_STATUS, {28'h0, p[0], p[1], p[3], p[2]}, 32'hf);
    bus(1'b1, tfb_pkg::OFF_IRQ_CLR, 32'hff);
    bus(1'b1, tfb_pkg::OFF_STATUS, st);
    rd(tfb_pkg::OFF_STATUS, st | (st >> 4), 32'hff00);
    @(posedge ref_clk_i);
    pins <= '0;
    idle(4);
    rd(tfb_pkg::OFF_STATUS, st, 32'hff00);
    if (how == 0) begin
      bus(1'b1, tfb_pkg::OFF_STATUS, st);
    end else begin
      @(posedge ref_clk_i);
      res_a <= (how == 1);
      res_b <= (how == 2);
      @(posedge ref_clk_i);
      res_a <= 1'b0;
      res_b <= 1'b0;
    end
    wait_halt(1'b0);
    rd(tfb_pkg::OFF_STATUS, 32'h0, 32'hff00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) rd_q <= bus_req.rd;
  always @(negedge ref_clk_i) begin
    if (rd_q && exp_q.size() > 0) begin
      chk("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  initial begin
    idle(20000);
    chk("watchdog", 32'h1, 32'h0);
    results();
  end
  initial begin
    rst_i = 1'b1;
    bus_req = '0;
    pins = '0;
    {res_a, res_b, upd} = 3'h0;
    cmp_lvl = 4'h0;
    capt_stb = 4'h0;
    capt_val = '0;
    idle(4);
    rst_i <= 1'b0;
    rd(tfb_pkg::OFF_STATUS, 32'h0, 32'hffffffff);
    rd(tfb_pkg::OFF_CTRL, tfb_pkg::CTRL_RST, 32'hffffffff);
    rd(tfb_pkg::OFF_IRQ_EN, 32'h0, 32'hffffffff);
    bus(1'b1, tfb_pkg::OFF_IRQ_STATUS, 32'hff);
    bus(1'b1, 8'h80, $random(seed));
    rd(tfb_pkg::OFF_IRQ_STATUS, 32'h0, 32'hffffffff);
    rd(8'h80, 32'h0, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      @(posedge ref_clk_i);
      cmp_lvl <= v[3:0];
      rd(tfb_pkg::OFF_STATUS, {4'h0, v[3:0], 24'h0}, 32'h0f000000);
    end
    $display("test reset and levels done");
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      bus(1'b1, tfb_pkg::OFF_BUF_BASE + 8'(4 * i), v);
      rd(tfb_pkg::OFF_STATUS, 32'h1 << (16 + i), 32'h000f0000);
      rd(tfb_pkg::OFF_BUF_BASE + 8'(4 * i), v, 32'hffffffff);
      bus(1'b1, tfb_pkg::OFF_STATUS, 32'h1 << (16 + i));
      rd(tfb_pkg::OFF_STATUS, 32'h1 << (16 + i), 32'h000f0000);
      bus(1'b1, tfb_pkg::OFF_CTRL, 32'h1);
      bus(1'b1, tfb_pkg::OFF_STATUS, 32'h1 << (16 + i));
      rd(tfb_pkg::OFF_STATUS, 32'h0, 32'h000f0000);
      bus(1'b1, tfb_pkg::OFF_CTRL, 32'h0);
      bus(1'b1, tfb_pkg::OFF_BUF_BASE + 8'(4 * i), v);
      @(posedge ref_clk_i);
      upd <= 1'b1;
      @(posedge ref_clk_i);
      upd <= 1'b0;
      idle(1);
      chk("cc_value", cc_val[32*i +: 32], v);
      rd(tfb_pkg::OFF_STATUS, 32'h0, 32'h000f0000);
    end
    $display("test compare done");
    bus(1'b1, tfb_pkg::OFF_CTRL, 32'hf0);
    bus(1'b1, tfb_pkg::OFF_IRQ_EN, 32'hf0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      cap(i, v);
      chk("irq", {31'h0, irq}, 32'h1);
      chk("cc_value", cc_val[32*i +: 32], v);
      rd(tfb_pkg::OFF_STATUS, 32'h1 << (16 + i), 32'h000f0000);
      rd(tfb_pkg::OFF_CC_BASE + 8'(4 * i), v, 32'hffffffff);
      rd(tfb_pkg::OFF_STATUS, 32'h0, 32'h000f0000);
      bus(1'b1, tfb_pkg::OFF_IRQ_CLR, 32'hff);
      idle(1);
      chk("irq", {31'h0, irq}, 32'h0);
    end
    bus(1'b1, tfb_pkg::OFF_IRQ_EN, 32'h0);
    cap(0, $random(seed));
    chk("irq", {31'h0, irq}, 32'h0);
    rd(tfb_pkg::OFF_IRQ_STATUS, 32'h10, 32'hff);
    bus(1'b1, tfb_pkg::OFF_IRQ_EN, 32'hf0);
    idle(1);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, tfb_pkg::OFF_IRQ_CLR, 32'hff);
    bus(1'b1, tfb_pkg::OFF_IRQ_EN, 32'h0);
    $display("test capture and irq done");
    flt(4'b0100, 32'h4000, 1'b1, 0);
    flt(4'b1000, 32'h8000, 1'b1, 0);
    flt(4'b0010, 32'h2000, 1'b0, 2);
    bus(1'b1, tfb_pkg::OFF_CTRL, 32'h2);
    flt(4'b0010, 32'h2000, 1'b1, 2);
    flt(4'b0010, 32'h2000, 1'b1, 0);
    flt(4'b0001, 32'h1000, 1'b0, 1);
    idle(3);
    $display("test faults done");
    results();
  end
endmodule
bind tfb_top tfb_properties #(.DW(DW)) u_prop (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .bus_req_i(bus_req_i), .rdata_o(rdata_o), .chan_compare_level_i(chan_compare_level_i),
  .fault_pins_i(fault_pins_i), .recov_fault_a_resume_i(recov_fault_a_resume_i),
  .recov_fault_b_resume_i(recov_fault_b_resume_i), .update_i(update_i),
  .capt_stb_i(capt_stb_i), .capt_val_i(capt_val_i), .cc_value_o(cc_value_o),
  .counter_halt_o(counter_halt_o), .irq_o(irq_o));
